//--- rtl/osc_select_pll_map.vh
// register offsets, field positions and reset values of the clock configuration block
`ifndef OSC_SELECT_PLL_MAP_VH
`define OSC_SELECT_PLL_MAP_VH
`define CLK_CFG_OFFSET 12'h060
`define PLL_XLAT_OFFSET 12'h064
`define CRYSTAL_FREQ_SELECT_MSB 9
`define CRYSTAL_FREQ_SELECT_LSB 6
`define OSCSEL_MSB 5
`define OSCSEL_LSB 4
`define INTERNAL_OSC_DIS_BIT 1
`define MAIN_OSCILLATOR_DIS_BIT 0
`define CRYSTAL_FREQ_SELECT_RESET 4'hB
`define OSCSEL_RESET 2'h1
`define INTERNAL_OSC_DIS_RESET 1'h0
`define MAIN_OSCILLATOR_DIS_RESET 1'h1
`define MULT_MSB 13
`define MULT_LSB 5
`define RDIV_MSB 4
`define RDIV_LSB 0
`define OSC_MAIN 2'h0
`define OSC_INT 2'h1
`define OSC_INT_DIV4 2'h2
`define OSC_SLOW 2'h3
`endif

//--- rtl/pll_xlat_table.v
// crystal code to pll multiplier and reference divider lookup
`timescale 1ns/1ps
module pll_xlat_table (
  input wire [3:0] crystal_freq_select_code,
  output reg [8:0] mult,
  output reg [4:0] rdiv
);
  // vco 400 MHz = crystal_freq_select * (mult + 1) / (rdiv + 1), approximated for fractional crystals
  always @* begin
    case (crystal_freq_select_code)
      4'h4: begin mult = 9'h0C7; rdiv = 5'h01; end
      4'h5: begin mult = 9'h0D9; rdiv = 5'h01; end
      4'h6: begin mult = 9'h063; rdiv = 5'h00; end
      4'h7: begin mult = 9'h0C2; rdiv = 5'h01; end
      4'h8: begin mult = 9'h0A2; rdiv = 5'h01; end
      4'h9: begin mult = 9'h04F; rdiv = 5'h00; end
      4'hA: begin mult = 9'h09B; rdiv = 5'h01; end
      4'hB: begin mult = 9'h063; rdiv = 5'h01; end
      4'hC: begin mult = 9'h081; rdiv = 5'h01; end
      4'hD: begin mult = 9'h06B; rdiv = 5'h01; end
      4'hE: begin mult = 9'h031; rdiv = 5'h00; end
      4'hF: begin mult = 9'h060; rdiv = 5'h01; end
      default: begin mult = 9'h000; rdiv = 5'h00; end
    endcase
  end
endmodule // pll_xlat_table

//--- rtl/osc_select_pll_translation.v
// run-mode oscillator select and crystal to pll translation registers on ahb-lite
`timescale 1ns/1ps
`include "osc_select_pll_map.vh"
module osc_select_pll_translation (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  output wire [1:0] osc_input_select,
  output wire internal_osc_disable,
  output wire main_osc_disable,
  output wire [8:0] pll_mult,
  output wire [4:0] pll_rdiv
);
  reg [3:0] crystal_freq_select_ff;
  reg [1:0] oscsel_ff;
  reg internal_osc_dis_ff;
  reg main_oscillator_dis_ff;
  reg [8:0] mult_ff;
  reg [4:0] rdiv_ff;
  reg wr_pend_ff;
  reg [11:0] addr_ff;
  wire [8:0] nxt_mult;
  wire [4:0] nxt_rdiv;
  wire [31:0] cfg_word;
  wire [31:0] xlat_word;
  wire addr_phase;
  wire wr_cfg;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_cfg = wr_pend_ff & (addr_ff == `CLK_CFG_OFFSET);

  pll_xlat_table u_table (
    .crystal_freq_select_code(crystal_freq_select_ff),
    .mult(nxt_mult),
    .rdiv(nxt_rdiv)
  );

  // capture address phase; writes commit in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 12'h000;
    end else begin
      wr_pend_ff <= addr_phase & hwrite;
      if (addr_phase) begin
        addr_ff <= {haddr[11:2], 2'b00};
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crystal_freq_select_ff <= `CRYSTAL_FREQ_SELECT_RESET;
      oscsel_ff <= `OSCSEL_RESET;
      internal_osc_dis_ff <= `INTERNAL_OSC_DIS_RESET;
      main_oscillator_dis_ff <= `MAIN_OSCILLATOR_DIS_RESET;
    end else if (wr_cfg) begin
      crystal_freq_select_ff <= hwdata[`CRYSTAL_FREQ_SELECT_MSB:`CRYSTAL_FREQ_SELECT_LSB];
      oscsel_ff <= hwdata[`OSCSEL_MSB:`OSCSEL_LSB];
      internal_osc_dis_ff <= hwdata[`INTERNAL_OSC_DIS_BIT];
      main_oscillator_dis_ff <= hwdata[`MAIN_OSCILLATOR_DIS_BIT];
    end
  end

  // translation follows the crystal code one cycle later; reset value matches code B
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mult_ff <= 9'h063;
      rdiv_ff <= 5'h01;
    end else begin
      mult_ff <= nxt_mult;
      rdiv_ff <= nxt_rdiv;
    end
  end

  assign cfg_word = {22'h000000, crystal_freq_select_ff, oscsel_ff, 2'b00, internal_osc_dis_ff, main_oscillator_dis_ff};
  assign xlat_word = {18'h00000, mult_ff, rdiv_ff};

  // read data registered at the address phase edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      case ({haddr[11:2], 2'b00})
        `CLK_CFG_OFFSET: hrdata <= cfg_word;
        `PLL_XLAT_OFFSET: hrdata <= xlat_word;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  assign osc_input_select = oscsel_ff;
  assign internal_osc_disable = internal_osc_dis_ff;
  assign main_osc_disable = main_oscillator_dis_ff;
  assign pll_mult = mult_ff;
  assign pll_rdiv = rdiv_ff;
endmodule // osc_select_pll_translation

//--- tb/osc_pll_properties.sv
// checker of bus read data and field update timing
`timescale 1ns/1ps
module osc_pll_chk (
  input wire hclk, hresetn, hsel, hwrite, hready,
  input wire [11:0] haddr,
  input wire [1:0] htrans, osc_input_select,
  input wire [31:0] hrdata, hwdata,
  input wire internal_osc_disable, main_osc_disable,
  input wire [8:0] pll_mult,
  input wire [4:0] pll_rdiv
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire go = hsel && hready && htrans[1];
  wire w60 = go && hwrite && haddr == 12'h060;
  wire r60 = go && !hwrite && haddr == 12'h060;
  wire r64 = go && !hwrite && haddr == 12'h064;
  wire [3:0] cfg = {osc_input_select, internal_osc_disable, main_osc_disable};
  AST_RST: assert property ($rose(hresetn) |-> cfg == 4'h5 && pll_mult == 9'h063)
    else $error("bad reset fields");
  AST_RD64: assert property (r64 |=> hrdata == {18'h0, $past(pll_mult), $past(pll_rdiv)})
    else $error("bad pll read");
  AST_RD60: assert property (r60 |=> hrdata[31:10] == 22'h0 && hrdata[3:2] == 2'h0)
    else $error("bad config read");
  AST_WR: assert property (w60 |-> ##2 cfg == {$past(hwdata[5:4]), $past(hwdata[1:0])})
    else $error("field not written");
  AST_HOLD: assert property ($changed(cfg) |-> $past(w60, 2))
    else $error("field changed unasked");
  AST_PHOLD: assert property ($changed(pll_mult) |-> $past(w60, 3))
    else $error("pll changed unasked");
  AST_XB: assert property (w60 ##1 hwdata[9:6] == 4'hB |-> ##2 pll_rdiv == 5'h01)
    else $error("bad divider for code b");
  AST_XE: assert property (w60 ##1 hwdata[9:6] == 4'hE |-> ##2 pll_mult == 9'h031)
    else $error("bad multiplier for code e");
endmodule // osc_pll_chk
bind osc_select_pll_translation osc_pll_chk u_chk (.*);

//--- tb/tb_top.sv
// self-checking bench of the clock configuration block
`timescale 1ns/1ps
module tb_top;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  reg [11:0] haddr = 0;
  reg [1:0] htrans = 0;
  reg [31:0] hwdata = 0, rdv;
  wire hreadyout, hresp, internal_osc_disable, main_osc_disable;
  wire [31:0] hrdata;
  wire [1:0] osc_input_select;
  wire [8:0] pll_mult;
  wire [4:0] pll_rdiv;
  integer bad_count = 0, n_checks = 0, i;
  always #25 hclk = ~hclk;
  osc_select_pll_translation DUT (.*, .hsize(3'h2), .hready(hreadyout));
  task chk(input [31:0] g, input [31:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
      bad_count = bad_count + 1;
    end
  endtask
  task xf(input w, input [11:0] a, input [31:0] d);
    hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0; hsel <= 0; hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
    @(posedge hclk);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_rst;
    xf(0, 12'h060, 0); chk(rdv, 32'h000002D1);
    xf(0, 12'h064, 0); chk(rdv, 32'h00000C61);
    chk({30'h0, hreadyout, hresp}, 32'h00000002);
    $display("t_rst done");
  endtask
  task t_rw;
    xf(1, 12'h060, 32'hFFFFFFFF); xf(0, 12'h060, 0); chk(rdv, 32'h000003F3);
    xf(0, 12'h064, 0); chk(rdv, 32'h00000C01);
    for (i = 0; i < 4; i = i + 1) begin
      xf(1, 12'h060, 32'h382 | (i << 4));
      chk({28'h0, osc_input_select, internal_osc_disable, main_osc_disable}, 4 * i + 2);
      xf(0, 12'h064, 0); chk(rdv, 32'h00000620);
    end
    $display("t_rw done");
  endtask
  task t_ro;
    xf(1, 12'h064, 0); xf(0, 12'h064, 0); chk(rdv, 32'h00000620);
    xf(1, 12'h060, 32'h2D1); xf(0, 12'h064, 0); chk(rdv, 32'h00000C61);
    xf(1, 12'h100, 32'hFFFFFFFF); xf(0, 12'h060, 0); chk(rdv, 32'h000002D1);
    xf(0, 12'h100, 0); chk(rdv, 0);
    chk({30'h0, hreadyout, hresp}, 32'h00000002);
    $display("t_ro done");
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    t_rst; t_rw; t_ro;
    test_done;
  end
  initial begin
    #100000;
    bad_count = bad_count + 1;
    test_done;
  end
endmodule // tb_top
